// [verilog/stp_pkg.sv]
// Purpose: constants and types of the serial packetizer
// Assumes: 100 MHz clk_sys, AHB-Lite register access, 32-bit words
// Notes: Contract list below
// Contract
// - pass-through and sharing modes frame identically; only RTS drive differs
// - received characters become print packets sent along the target route
// - a carriage return closes the current packet
// - the packet closes when its character count reaches the size limit
// - a gap between characters longer than the time limit closes the packet
// - size limit one forwards every character at once as its own packet
// - nothing of a packet leaves before one of its closing events
// - the target route can be rewritten at run time by write messages
// - point-to-point mode drives always and keeps the receiver on
// - cts-gated mode drives only while cts is asserted
// - half-duplex mode drives always, receiver off while transmitting
// - two-wire mode drives while cts, receiver off while transmitting
package stp_pkg;
   // ===============================================
   // timing
   localparam int unsigned CLK_NS = 10;
   localparam int unsigned TICK_NS = 10_000_000;
   localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;
   // ===============================================
   // register map
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SIZE = 8'h04;
   localparam logic [7:0] ADDR_TIME = 8'h08;
   localparam logic [7:0] ADDR_ROUTE = 8'h0c;
   localparam logic [7:0] ADDR_STAT = 8'h10;
   localparam int unsigned CTRL_EN_BIT = 0;
   localparam int unsigned CTRL_SHARE_BIT = 1;
   localparam int unsigned CTRL_DRV_LSB = 4;
   localparam int unsigned STAT_SEND_BIT = 8;
   localparam int unsigned STAT_NPKT_LSB = 16;
   localparam logic RST_EN = 1'b1;
   localparam logic RST_SHARE = 1'b0;
   localparam logic [7:0] RST_SIZE = 8'h80;
   localparam logic [7:0] RST_TIME = 8'h64;
   localparam logic [31:0] RST_ROUTE = 32'h0;
   localparam logic [7:0] ASCII_CR = 8'h0d;
   // ===============================================
   // types
   typedef enum logic [1:0] {
      DRV_FULL_DUPLEX_ALWAYS_DRIVE,
      DRV_CTS_GATED_DRIVER,
      DRV_HALF_DUPLEX,
      DRV_TWO_WIRE
   } stp_drv_e;
   localparam stp_drv_e RST_DRV = DRV_FULL_DUPLEX_ALWAYS_DRIVE;
endpackage : stp_pkg

// [verilog/stp_buf2.sv]
// Purpose: two-entry valid/ready buffer in the packet byte path
// Assumes: single clock, asynchronous active-high reset
// Notes: in_ready stays high while one slot is free
`timescale 1ns/10ps
module stp_buf2 #(
   parameter int unsigned W = 9
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   typedef struct packed {
      logic [1:0] n;
      logic [W-1:0] e0;
      logic [W-1:0] e1;
   } stp_buf_s;
   stp_buf_s s_q;
   stp_buf_s s_d;
   logic push;
   logic pop;

   assign in_ready = (s_q.n != 2'd2);
   assign out_valid = (s_q.n != 2'd0);
   assign out_data = s_q.e0;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      s_d = s_q;
      if (pop) begin
         s_d.e0 = s_q.e1;
      end
      if (push) begin
         if (s_q.n == 2'd0 || (s_q.n == 2'd1 && pop)) begin
            s_d.e0 = in_data;
         end else begin
            s_d.e1 = in_data;
         end
      end
      s_d.n = s_q.n + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   a_buf_bound: assert property (@(posedge clk_sys) disable iff (sys_rst) s_q.n <= 2'd2)
      else $error("buffer count above two");
endmodule : stp_buf2

// [verilog/stp_packetizer.sv]
// Purpose: gathers received characters into packets and forwards them with a route
// Assumes: rx characters arrive on a valid/ready handshake, held until taken, synchronous to clk_sys
// Notes: AHB-Lite slave with zero wait states; packet bytes leave via stp_buf2
`timescale 1ns/10ps
module stp_packetizer #(
   parameter int unsigned DEPTH = 128,
   parameter int unsigned TICK_CYC = stp_pkg::TICK_CYC
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   output logic rx_ready,
   input wire logic route_wr_valid,
   input wire logic [31:0] route_wr_data,
   output logic pkt_valid,
   input wire logic pkt_ready,
   output logic [7:0] pkt_data,
   output logic pkt_last,
   output logic [31:0] pkt_route,
   input wire logic cts,
   input wire logic tx_busy,
   output logic tx_drv_en,
   output logic rx_en,
   output logic share_mode
);
   import stp_pkg::*;

   // ===============================================
   // state
   localparam int unsigned AW = $clog2(DEPTH);
   localparam int unsigned DW = $clog2(TICK_CYC);
   localparam logic [7:0] LIM_MAX = 8'(DEPTH);
   localparam logic [DW-1:0] DIV_LAST = DW'(TICK_CYC - 1);

   typedef enum logic {ST_COLLECT, ST_SEND} stp_st_e;

   typedef struct packed {
      stp_st_e st;
      logic [7:0] cnt;
      logic [7:0] rd;
      logic [7:0] gap;
      logic [DW-1:0] div;
      logic en;
      logic share;
      stp_drv_e drv;
      logic [7:0] size;
      logic [7:0] tlim;
      logic [31:0] route;
      logic [31:0] pkt_route;
      logic [15:0] npkt;
      logic ahb_wr;
      logic [7:0] ahb_adr;
      logic [31:0] rdata;
   } stp_state_s;

   stp_state_s s_q;
   stp_state_s s_d;
   logic [7:0] mem [DEPTH];
   logic [7:0] lim;
   logic accept;
   logic tick;
   logic tmo;
   logic last_byte;
   logic buf_in_valid;
   logic buf_in_ready;
   logic ahb_take;

   // ===============================================
   // driver control
   always_comb begin
      unique case (s_q.drv)
         DRV_FULL_DUPLEX_ALWAYS_DRIVE: begin
            tx_drv_en = 1'b1;
            rx_en = 1'b1;
         end
         DRV_CTS_GATED_DRIVER: begin
            tx_drv_en = cts;
            rx_en = 1'b1;
         end
         DRV_HALF_DUPLEX: begin
            tx_drv_en = 1'b1;
            rx_en = !tx_busy;
         end
         DRV_TWO_WIRE: begin
            tx_drv_en = cts;
            rx_en = !tx_busy;
         end
      endcase
   end

   // the share bit only reaches the rts logic outside; framing ignores it
   assign share_mode = s_q.share;

   // ===============================================
   // assembly
   // a zero or oversized limit falls back to the storage depth
   assign lim = (s_q.size == 8'h00 || s_q.size > LIM_MAX) ? LIM_MAX : s_q.size;
   assign rx_ready = s_q.en && rx_en && (s_q.st == ST_COLLECT);
   assign accept = rx_valid && rx_ready;
   assign tick = (s_q.div == DIV_LAST);
   // a zero time limit disables the timeout
   assign tmo = (s_q.st == ST_COLLECT) && !accept && tick && (s_q.cnt != 8'h00)
      && (s_q.tlim != 8'h00) && (s_q.gap >= s_q.tlim);
   assign last_byte = (s_q.rd == s_q.cnt - 8'h01);
   assign buf_in_valid = (s_q.st == ST_SEND);
   assign ahb_take = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_q.rdata;

   always_ff @(posedge clk_sys) begin
      if (accept) begin
         mem[s_q.cnt[AW-1:0]] <= rx_data;
      end
   end

   always_comb begin
      s_d = s_q;
      s_d.div = tick ? '0 : s_q.div + DW'(1);
      unique case (s_q.st)
         ST_COLLECT: begin
            if (accept) begin
               s_d.cnt = s_q.cnt + 8'h01;
               s_d.gap = 8'h00;
               if (rx_data == ASCII_CR || s_q.cnt + 8'h01 >= lim) begin
                  s_d.st = ST_SEND;
               end
            end else if (tmo) begin
               s_d.st = ST_SEND;
            end else if (s_q.cnt == 8'h00) begin
               s_d.gap = 8'h00;
            end else if (tick && s_q.gap != 8'hff) begin
               s_d.gap = s_q.gap + 8'h01;
            end
            if (s_d.st == ST_SEND) begin
               s_d.rd = 8'h00;
               s_d.gap = 8'h00;
               s_d.pkt_route = s_q.route;
            end
         end
         ST_SEND: begin
            if (buf_in_ready) begin
               s_d.rd = s_q.rd + 8'h01;
               if (last_byte) begin
                  s_d.st = ST_COLLECT;
                  s_d.cnt = 8'h00;
                  s_d.npkt = s_q.npkt + 16'h0001;
               end
            end
         end
      endcase
      // ===============================================
      // register bus
      s_d.ahb_wr = ahb_take && hwrite;
      s_d.ahb_adr = haddr[7:0];
      if (ahb_take && !hwrite) begin
         s_d.rdata = 32'h0;
         unique case (haddr[7:0])
            ADDR_CTRL: begin
               s_d.rdata[CTRL_EN_BIT] = s_q.en;
               s_d.rdata[CTRL_SHARE_BIT] = s_q.share;
               s_d.rdata[CTRL_DRV_LSB +: 2] = s_q.drv;
            end
            ADDR_SIZE: s_d.rdata[7:0] = s_q.size;
            ADDR_TIME: s_d.rdata[7:0] = s_q.tlim;
            ADDR_ROUTE: s_d.rdata = s_q.route;
            ADDR_STAT: begin
               s_d.rdata[7:0] = s_q.cnt;
               s_d.rdata[STAT_SEND_BIT] = (s_q.st == ST_SEND);
               s_d.rdata[STAT_NPKT_LSB +: 16] = s_q.npkt;
            end
            default: s_d.rdata = 32'h0;
         endcase
      end
      if (s_q.ahb_wr) begin
         unique case (s_q.ahb_adr)
            ADDR_CTRL: begin
               s_d.en = hwdata[CTRL_EN_BIT];
               s_d.share = hwdata[CTRL_SHARE_BIT];
               s_d.drv = stp_drv_e'(hwdata[CTRL_DRV_LSB +: 2]);
            end
            ADDR_SIZE: s_d.size = hwdata[7:0];
            ADDR_TIME: s_d.tlim = hwdata[7:0];
            ADDR_ROUTE: s_d.route = hwdata;
            default: s_d.route = s_d.route;
         endcase
      end
      // a route message overrides a bus write in the same cycle
      if (route_wr_valid) begin
         s_d.route = route_wr_data;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         s_q <= '0;
         s_q.st <= ST_COLLECT;
         s_q.en <= RST_EN;
         s_q.share <= RST_SHARE;
         s_q.drv <= RST_DRV;
         s_q.size <= RST_SIZE;
         s_q.tlim <= RST_TIME;
         s_q.route <= RST_ROUTE;
      end else begin
         s_q <= s_d;
      end
   end

   // ===============================================
   // output buffer
   // the route rides with each byte, so a stalled byte keeps its own packet's route
   stp_buf2 #(
      .W(41)
   ) u_buf (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .in_valid(buf_in_valid),
      .in_ready(buf_in_ready),
      .in_data({s_q.pkt_route, last_byte, mem[s_q.rd[AW-1:0]]}),
      .out_valid(pkt_valid),
      .out_ready(pkt_ready),
      .out_data({pkt_route, pkt_last, pkt_data})
   );

   // ===============================================
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   // ===============================================
   // framing
   a_cr_closes: assert property (accept && rx_data == ASCII_CR |=> s_q.st == ST_SEND)
      else $error("carriage return did not close packet");
   a_size_closes: assert property (accept && s_q.cnt + 8'h01 >= lim
      |=> s_q.st == ST_SEND && s_q.cnt == $past(s_q.cnt) + 8'h01)
      else $error("size limit did not close packet");
   a_tmo_closes: assert property (tmo |=> s_q.st == ST_SEND && s_q.gap == 8'h00)
      else $error("timeout did not close packet");
   a_size_one: assert property (s_q.size == 8'h01 && accept
      |=> buf_in_valid && last_byte && s_q.cnt == 8'h01)
      else $error("single character not forwarded at once");
   // a close with none of its three causes would leak a partial packet
   a_no_early: assert property ($rose(s_q.st == ST_SEND)
      |-> $past(tmo || (accept && (rx_data == ASCII_CR || s_q.cnt + 8'h01 >= lim))))
      else $error("packet closed with no closing event");
   a_last_close: assert property (buf_in_valid && buf_in_ready && last_byte
      |=> s_q.st == ST_COLLECT && s_q.cnt == 8'h00)
      else $error("packet did not reopen after its last byte");
   a_gap_restart: assert property (accept |=> s_q.gap == 8'h00)
      else $error("gap timer not restarted");
   a_gap_idle: assert property (s_q.cnt == 8'h00 ##1 s_q.cnt == 8'h00
      |-> s_q.gap == 8'h00)
      else $error("gap timer running with no packet");

   // ===============================================
   // routing and output
   a_route_upd: assert property (route_wr_valid |=> s_q.route == $past(route_wr_data))
      else $error("route write lost");
   a_route_pkt: assert property ($rose(s_q.st == ST_SEND)
      |-> s_q.pkt_route == $past(s_q.route))
      else $error("packet route not taken at close");
   a_route_hold: assert property (s_q.st == ST_SEND |=> $stable(s_q.pkt_route))
      else $error("packet route changed while draining");
   a_drain_order: assert property (buf_in_valid && buf_in_ready && !last_byte
      |=> s_q.st == ST_SEND && s_q.rd == $past(s_q.rd) + 8'h01)
      else $error("packet bytes skipped or repeated");
   // a stalled byte must keep data, marker and route together
   a_pkt_hold: assert property (pkt_valid && !pkt_ready
      |=> pkt_valid && $stable({pkt_route, pkt_last, pkt_data}))
      else $error("packet byte changed while stalled");

   // ===============================================
   // driver modes
   // receiver gating is checked through rx_ready, which is what the terminal obeys
   a_drv_pt: assert property (s_q.drv == DRV_FULL_DUPLEX_ALWAYS_DRIVE
      |-> tx_drv_en && rx_en)
      else $error("point-to-point drive wrong");
   a_drv_cts: assert property (s_q.drv == DRV_CTS_GATED_DRIVER
      |-> tx_drv_en == cts && rx_en)
      else $error("cts-gated drive wrong");
   a_drv_half: assert property (s_q.drv == DRV_HALF_DUPLEX && tx_busy
      |-> tx_drv_en && !rx_ready)
      else $error("half duplex echo not blocked");
   a_drv_two: assert property (s_q.drv == DRV_TWO_WIRE && tx_busy
      |-> tx_drv_en == cts && !rx_ready)
      else $error("two-wire drive wrong");

   c_cr_pkt: cover property (accept && rx_data == ASCII_CR ##[1:20] pkt_valid && pkt_last);
   c_tmo_pkt: cover property (tmo ##[1:20] pkt_valid && pkt_last);
   c_stall: cover property (pkt_valid && !pkt_ready [*3] ##1 !buf_in_ready);
   c_size_one: cover property (s_q.size == 8'h01 && accept ##2 pkt_valid && pkt_last);
   c_route_msg: cover property (route_wr_valid ##[1:60] pkt_valid && pkt_route == s_q.route);
endmodule : stp_packetizer

// [tb/stp_term.sv]
// Purpose: serial terminal model that feeds characters to the packetizer
// Assumes: a character is taken at the rising edge where rx_valid and rx_ready are high
// Notes: idle data shows the inverse of the last character, never a stale copy
`timescale 1ns/10ps
module stp_term (
   input wire logic clk_sys,
   input wire logic rx_ready,
   output logic rx_valid,
   output logic [7:0] rx_data
);
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
   end
   // ===============================================
   // one character after gap + 1 idle cycles, held until taken
   task automatic send(input logic [7:0] b, input int gap, output bit ok);
      int i;
      @(posedge clk_sys);
      repeat (gap) @(posedge clk_sys);
      rx_valid <= 1'b1;
      rx_data <= b;
      i = 0;
      // ready is read mid-cycle so the sampling edge never races the design
      do begin
         @(negedge clk_sys);
         i++;
      end while (rx_ready !== 1'b1 && i < 300);
      ok = (rx_ready === 1'b1);
      @(posedge clk_sys);
      rx_valid <= 1'b0;
      rx_data <= ~b;
   endtask : send
endmodule : stp_term

// [tb/serial_transparent_packetizer_tb.sv]
// Purpose: self-checking bench of the packetizer
// Assumes: AHB-Lite slave that answers within 49 cycles, TICK_CYC of 10 cycles
// Notes: sink stalls at random to push the two-entry buffer
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module serial_transparent_packetizer_tb;
   import stp_pkg::*;
   logic clk_sys = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, route_wr_data = 32'h0, pkt_route;
   logic [1:0] htrans = 2'b00;
   logic hreadyout, hresp, rx_valid, rx_ready, pkt_valid, pkt_last;
   logic route_wr_valid = 1'b0, pkt_ready = 1'b1, cts = 1'b0, tx_busy = 1'b0;
   logic [7:0] rx_data, pkt_data;
   logic tx_drv_en, rx_en, share_mode;
   logic [31:0] cur_route;
   logic [40:0] exp_q[$], got_q[$];
   int n_errors = 0, check_count = 0;
   always #5 clk_sys = ~clk_sys;
   stp_packetizer #(.DEPTH(8), .TICK_CYC(10)) u_stp_packetizer (.clk_sys(clk_sys),
      .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_ready(rx_ready), .route_wr_valid(route_wr_valid), .route_wr_data(route_wr_data),
      .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .pkt_data(pkt_data),
      .pkt_last(pkt_last), .pkt_route(pkt_route), .cts(cts), .tx_busy(tx_busy),
      .tx_drv_en(tx_drv_en), .rx_en(rx_en), .share_mode(share_mode));
   stp_term u_stp_term (.clk_sys(clk_sys), .rx_ready(rx_ready), .rx_valid(rx_valid),
      .rx_data(rx_data));
   // ===============================================
   // sink: transfers seen mid-cycle, ready redrawn after each edge
   always @(negedge clk_sys) begin
      if (pkt_valid === 1'b1 && pkt_ready === 1'b1) begin
         got_q.push_back({pkt_route, pkt_last, pkt_data});
      end
   end
   always @(posedge clk_sys) begin
      if (!sys_rst) begin
         pkt_ready <= ($urandom % 3) != 0;
      end
   end
   task automatic test_done();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : test_done
   task automatic wait_rdy(output logic [31:0] rd);
      int i;
      i = 0;
      do begin
         @(negedge clk_sys);
         rd = hrdata;
         i++;
      end while (hreadyout !== 1'b1 && i < 50);
      if (i >= 50) begin
         n_errors++;
         test_done();
      end
      @(posedge clk_sys);
   endtask : wait_rdy
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      wait_rdy(rd);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy(rd);
      `CHK(hresp, 1'b0)
   endtask : bus
   function automatic logic [7:0] rnd_char();
      return 8'h20 + 8'($urandom % 95);
   endfunction : rnd_char
   task automatic snd(input logic [7:0] b, input int gap, input logic last);
      bit ok;
      u_stp_term.send(b, gap, ok);
      if (!ok) begin
         n_errors++;
         test_done();
      end
      exp_q.push_back({cur_route, last, b});
   endtask : snd
   task automatic check_pkts();
      int i;
      i = 0;
      while (got_q.size() < exp_q.size() && i < 2000) begin
         @(negedge clk_sys);
         i++;
      end
      `CHK(got_q.size(), exp_q.size())
      if (got_q.size() < exp_q.size()) begin
         test_done();
      end
      foreach (exp_q[k]) if (k < got_q.size()) `CHK(got_q[k], exp_q[k])
      exp_q.delete();
      got_q.delete();
   endtask : check_pkts
   // ===============================================
   // main sequence
   logic [7:0] ra[6] = '{ADDR_CTRL, ADDR_SIZE, ADDR_TIME, ADDR_ROUTE, ADDR_STAT, 8'h14};
   logic [31:0] rv[6] = '{{26'h0, RST_DRV, 2'b00, RST_SHARE, RST_EN}, {24'h0, RST_SIZE},
                         {24'h0, RST_TIME}, RST_ROUTE, 32'h0, 32'h0};
   initial begin
      logic [31:0] rd;
      int n;
      void'($urandom(32'hd8bf));
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      foreach (ra[k]) begin
         bus(1'b0, ra[k], 32'h0, rd);
         `CHK(rd, rv[k])
      end
      bus(1'b1, 8'h14, 32'hffffffff, rd);
      bus(1'b0, 8'h14, 32'h0, rd);
      `CHK(rd, 32'h0)
      cur_route = $urandom;
      bus(1'b1, ADDR_ROUTE, cur_route, rd);
      bus(1'b1, ADDR_SIZE, 32'h8, rd);
      bus(1'b1, ADDR_TIME, 32'h0, rd);
      snd(rnd_char(), 0, 1'b0);
      snd(rnd_char(), 3, 1'b0);
      snd(ASCII_CR, 0, 1'b1);
      check_pkts();
      bus(1'b1, ADDR_SIZE, 32'h4, rd);
      for (int k = 0; k < 4; k++) snd(rnd_char(), 0, k == 3);
      check_pkts();
      bus(1'b1, ADDR_SIZE, 32'h1, rd);
      for (int k = 0; k < 4; k++) snd(rnd_char(), 0, 1'b1);
      check_pkts();
      // a limit of two ticks stands for just over one character time
      bus(1'b1, ADDR_SIZE, 32'h8, rd);
      bus(1'b1, ADDR_TIME, 32'h2, rd);
      for (int k = 0; k < 3; k++) snd(rnd_char(), 15, k == 2);
      n = 0;
      while (pkt_valid !== 1'b1 && n < 100) begin
         @(negedge clk_sys);
         n++;
      end
      `CHK(n inside {[22:32]}, 1'b1)
      if (n >= 100) begin
         test_done();
      end
      check_pkts();
      @(posedge clk_sys);
      route_wr_valid <= 1'b1;
      route_wr_data <= ~cur_route;
      @(posedge clk_sys);
      route_wr_valid <= 1'b0;
      cur_route = ~cur_route;
      snd(rnd_char(), 0, 1'b0);
      snd(ASCII_CR, 0, 1'b1);
      check_pkts();
      bus(1'b0, ADDR_ROUTE, 32'h0, rd);
      `CHK(rd, cur_route)
      bus(1'b1, ADDR_CTRL, 32'h3, rd);
      repeat (2) @(negedge clk_sys);
      `CHK(share_mode, 1'b1)
      snd(rnd_char(), 0, 1'b0);
      snd(ASCII_CR, 0, 1'b1);
      check_pkts();
      // nine packets closed so far, none open
      bus(1'b0, ADDR_STAT, 32'h0, rd);
      `CHK(rd, 32'(9) << STAT_NPKT_LSB)
      for (int m = 0; m < 4; m++) begin
         bus(1'b1, ADDR_CTRL, 32'h1 | (m << 4), rd);
         for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            cts <= k[0];
            tx_busy <= k[1];
            @(negedge clk_sys);
            `CHK(tx_drv_en, m[0] ? k[0] : 1'b1)
            `CHK(rx_en, m[1] ? !k[1] : 1'b1)
            `CHK(rx_ready, m[1] ? !k[1] : 1'b1)
         end
      end
      bus(1'b1, ADDR_CTRL, 32'h0, rd);
      @(negedge clk_sys);
      `CHK(rx_ready, 1'b0)
      test_done();
   end
   initial begin
      #900_000;
      n_errors++;
      test_done();
   end
endmodule : serial_transparent_packetizer_tb
